// >>> ics_pkg.sv
// Constants for the interrupt control and context save block.
package ics_pkg;
   localparam logic [7:0] OFS_CTL = 8'h00;
   localparam logic [7:0] OFS_PIE = 8'h04;
   localparam logic [7:0] OFS_PIR = 8'h08;
   localparam logic [7:0] OFS_IOC = 8'h0c;
   localparam logic [7:0] OFS_SH_W = 8'h10;
   localparam logic [7:0] OFS_SH_ST = 8'h14;
   localparam logic [7:0] OFS_SH_BSR = 8'h18;
   localparam logic [7:0] OFS_SH_FSR0 = 8'h1c;
   localparam logic [7:0] OFS_SH_FSR1 = 8'h20;
   localparam logic [7:0] OFS_SH_PCL = 8'h24;
   localparam logic [7:0] OFS_EVT_ST = 8'h28;
   localparam logic [7:0] OFS_EVT_CLR = 8'h2c;
   localparam logic [7:0] OFS_EVT_EN = 8'h30;
   localparam int B_GIE = 7;
   localparam int B_PERIPH_IRQ_GATE = 6;
   localparam int B_T0IE = 5;
   localparam int B_EXTIE = 4;
   localparam int B_PIN_CHANGE_EN = 3;
   localparam int B_T0IF = 2;
   localparam int B_EXTIF = 1;
   localparam int B_PIN_CHANGE_SUMMARY_FLAG = 0;
   localparam int E_ENTRY = 0;
   localparam int E_RETURN = 1;
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [7:0] PIE_RST = 8'h00;
   localparam logic [7:0] STATUS_SAVE_MASK = 8'he7;
   localparam logic [14:0] IRQ_VECTOR = 15'h0004;
   localparam logic [7:0] SHADOW_BANK = 8'h1f;
   typedef enum logic {ICS_RUN = 1'b0, ICS_ISR = 1'b1} ics_ctx_e;
endpackage

// >>> ics_irq.sv
// Interrupt gating, flag capture and automatic context save and restore.
`timescale 1ns/1ps
// Contract
// - Entry pushes PC and shadows core context.
// - Return reloads live registers from shadows.
// - Shadows software readable and writable, restored.
// - Flags set regardless of any enable.
// - Control bit 7 is global enable.
// - Control bit 6 gates peripheral sources.
// - Bits 5/2 enable and flag tick0 overflow.
// - Bits 4/1 enable and flag external edge.
// - Bits 3/0 enable and summarize pin change.
// - Summary flag read-only, clears with pin flags.
// - Enable bits 6,5,4,3 for four sources.
// - Enable bits 5,4,3 for three core sources.
// - Reset leaves every enable bit cleared.
// - Entry clears global enable, pushes, vectors 0004h.
// - Return pops, restores, sets global enable together.
module ics_irq
   import ics_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic tick0_ovf,
   input wire logic ext_pin,
   input wire logic [7:0] pin_change_in,
   input wire logic [7:0] periph_evt,
   input wire logic core_boundary,
   input wire logic core_ret,
   input wire logic [14:0] live_pc,
   input wire logic [7:0] live_w,
   input wire logic [7:0] live_status,
   input wire logic [4:0] live_bsr,
   input wire logic [15:0] live_fsr0,
   input wire logic [15:0] live_fsr1,
   input wire logic [6:0] live_pcl,
   output logic core_req,
   output logic vec_go,
   output logic [14:0] vec_addr,
   output logic push_go,
   output logic [14:0] push_pc,
   output logic pop_go,
   output logic restore_go,
   output logic [7:0] restore_w,
   output logic [7:0] restore_status,
   output logic [4:0] restore_bsr,
   output logic [15:0] restore_fsr0,
   output logic [15:0] restore_fsr1,
   output logic [6:0] restore_pcl,
   output logic irq
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [7:1] ctl;
      logic [7:0] pie;
      logic [7:0] pir;
      logic [7:0] ioc;
      logic [7:0] sh_w;
      logic [7:0] sh_st;
      logic [4:0] sh_bsr;
      logic [15:0] sh_fsr0;
      logic [15:0] sh_fsr1;
      logic [6:0] sh_pcl;
      logic [1:0] evt_st;
      logic [1:0] evt_en;
      logic irq;
      logic req;
      logic vec;
      logic [14:0] vaddr;
      logic push;
      logic [14:0] ppc;
      logic pop;
      logic rest;
      ics_ctx_e ctx;
      logic [2:0] ext_s;
      logic ext_q;
      logic [7:0] pc_s0;
      logic [7:0] pc_s1;
      logic [7:0] pc_s2;
      logic [7:0] pc_q;
   } ics_state_s;

   ics_state_s s;
   ics_state_s next_s;
   logic wr;
   logic [7:0] b0;
   logic [7:0] b1;
   logic pend;
   logic take;
   logic give;
   logic ext_edge;
   logic [7:0] pc_chg;

   function automatic logic [31:0] ics_rd(input ics_state_s c, input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0;
      case (a)
         // summary bit derived from pin flags.
         OFS_CTL: v = {24'h0, c.ctl, |c.ioc};
         OFS_PIE: v = {24'h0, c.pie};
         OFS_PIR: v = {24'h0, c.pir};
         OFS_IOC: v = {24'h0, c.ioc};
         OFS_SH_W: v = {24'h0, c.sh_w};
         OFS_SH_ST: v = {24'h0, c.sh_st};
         OFS_SH_BSR: v = {27'h0, c.sh_bsr};
         OFS_SH_FSR0: v = {16'h0, c.sh_fsr0};
         OFS_SH_FSR1: v = {16'h0, c.sh_fsr1};
         OFS_SH_PCL: v = {25'h0, c.sh_pcl};
         OFS_EVT_ST: v = {30'h0, c.evt_st};
         OFS_EVT_EN: v = {30'h0, c.evt_en};
         default: v = 32'h0;
      endcase
      return v;
   endfunction

   always_comb begin
      next_s = s;
      // Writes land on the edge where the master sees ack high.
      wr = wb_cyc_i && wb_stb_i && wb_we_i && s.ack;
      b0 = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h0;
      b1 = wb_dat_i[15:8];
      next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
      next_s.rdata = (wb_cyc_i && wb_stb_i && !s.ack) ? ics_rd(s, wb_adr_i) : 32'h0;
      // Only the second and third stages are compared, never the first.
      next_s.ext_s = {s.ext_s[1:0], ext_pin};
      next_s.pc_s0 = pin_change_in;
      next_s.pc_s1 = s.pc_s0;
      next_s.pc_s2 = s.pc_s1;
      ext_edge = (s.ext_s[1] == s.ext_s[2]) && s.ext_s[2] && !s.ext_q;
      if (s.ext_s[1] == s.ext_s[2]) begin
         next_s.ext_q = s.ext_s[2];
      end
      pc_chg = ~(s.pc_s1 ^ s.pc_s2) & (s.pc_s2 ^ s.pc_q);
      next_s.pc_q = (s.pc_q & ~pc_chg) | (s.pc_s2 & pc_chg);
      if (wr && wb_sel_i[0]) begin
         case (wb_adr_i)
            OFS_CTL: next_s.ctl = b0[7:1];
            OFS_PIE: next_s.pie = b0;
            OFS_PIR: next_s.pir = b0;
            OFS_IOC: next_s.ioc = b0;
            OFS_SH_W: next_s.sh_w = b0;
            OFS_SH_ST: next_s.sh_st = b0 & STATUS_SAVE_MASK;
            OFS_SH_BSR: next_s.sh_bsr = b0[4:0];
            OFS_SH_FSR0: next_s.sh_fsr0[7:0] = b0;
            OFS_SH_FSR1: next_s.sh_fsr1[7:0] = b0;
            OFS_SH_PCL: next_s.sh_pcl = b0[6:0];
            OFS_EVT_CLR: next_s.evt_st = s.evt_st & ~b0[1:0];
            OFS_EVT_EN: next_s.evt_en = b0[1:0];
            default: next_s.ack = next_s.ack;
         endcase
      end
      if (wr && wb_sel_i[1] && wb_adr_i == OFS_SH_FSR0) begin
         next_s.sh_fsr0[15:8] = b1;
      end
      if (wr && wb_sel_i[1] && wb_adr_i == OFS_SH_FSR1) begin
         next_s.sh_fsr1[15:8] = b1;
      end
      // flags set unconditionally; a set beats a same-cycle clear.
      next_s.pir = next_s.pir | periph_evt;
      next_s.ioc = next_s.ioc | pc_chg;
      if (tick0_ovf) begin
         next_s.ctl[B_T0IF] = 1'b1;
      end
      if (ext_edge) begin
         next_s.ctl[B_EXTIF] = 1'b1;
      end
      // gated request; peripheral gate; pin change path.
      pend = (s.ctl[B_T0IE] && s.ctl[B_T0IF]) || (s.ctl[B_EXTIE] && s.ctl[B_EXTIF])
         || (s.ctl[B_PIN_CHANGE_EN] && (|s.ioc)) || (s.ctl[B_PERIPH_IRQ_GATE] && (|(s.pie & s.pir)));
      give = core_ret && (s.ctx == ICS_ISR);
      // global enable blocks entry and the core request when clear; flags and irq are not gated.
      take = core_boundary && s.ctl[B_GIE] && pend && !give;
      next_s.req = pend && next_s.ctl[B_GIE];
      next_s.vec = take;
      next_s.push = take;
      next_s.pop = give;
      next_s.rest = give;
      // entry clears the global enable and loads the vector.
      if (take) begin
         next_s.ctl[B_GIE] = 1'b0;
         next_s.ppc = live_pc;
         next_s.vaddr = IRQ_VECTOR;
         next_s.ctx = ICS_ISR;
         // context shadowed on the entry edge.
         next_s.sh_w = live_w;
         next_s.sh_st = live_status & STATUS_SAVE_MASK;
         next_s.sh_bsr = live_bsr;
         next_s.sh_fsr0 = live_fsr0;
         next_s.sh_fsr1 = live_fsr1;
         next_s.sh_pcl = live_pcl;
         next_s.evt_st[E_ENTRY] = 1'b1;
      end
      // return pops, restores and re-enables together.
      if (give) begin
         next_s.ctl[B_GIE] = 1'b1;
         next_s.ctx = ICS_RUN;
         next_s.evt_st[E_RETURN] = 1'b1;
         next_s.req = pend;
      end
      next_s.irq = |(next_s.evt_st & next_s.evt_en);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.rdata;
   assign core_req = s.req;
   assign vec_go = s.vec;
   assign vec_addr = s.vaddr;
   assign push_go = s.push;
   assign push_pc = s.ppc;
   assign pop_go = s.pop;
   // restore values come straight from the shadows.
   assign restore_go = s.rest;
   assign restore_w = s.sh_w;
   assign restore_status = s.sh_st;
   assign restore_bsr = s.sh_bsr;
   assign restore_fsr0 = s.sh_fsr0;
   assign restore_fsr1 = s.sh_fsr1;
   assign restore_pcl = s.sh_pcl;
   assign irq = s.irq;

   property p_entry_ctx;
      @(posedge clk) disable iff (rst)
      (core_boundary && s.ctl[B_GIE] && pend && !give) |=>
         vec_go && push_go && restore_w == $past(live_w) && push_pc == $past(live_pc);
   endproperty
   a_entry_ctx: assert property (p_entry_ctx) else $error("entry context not captured");
   property p_ret;
      @(posedge clk) disable iff (rst)
      (core_ret && s.ctx == ICS_ISR) |=> restore_go && pop_go && s.ctl[B_GIE];
   endproperty
   a_ret: assert property (p_ret) else $error("return did not restore");
   property p_gie_off;
      @(posedge clk) disable iff (rst) vec_go |-> !s.ctl[B_GIE] && vec_addr == IRQ_VECTOR;
   endproperty
   a_gie_off: assert property (p_gie_off) else $error("entry left global enable");
   property p_no_gie;
      @(posedge clk) disable iff (rst) !s.ctl[B_GIE] |=> !vec_go;
   endproperty
   a_no_gie: assert property (p_no_gie) else $error("entry without global enable");
   property p_flag;
      @(posedge clk) disable iff (rst)
      (|periph_evt) |=> (s.pir & $past(periph_evt)) == $past(periph_evt);
   endproperty
   a_flag: assert property (p_flag) else $error("flag lost");
   property p_t0;
      @(posedge clk) disable iff (rst) tick0_ovf |=> s.ctl[B_T0IF];
   endproperty
   a_t0: assert property (p_t0) else $error("tick0 flag missing");
   property p_sum;
      @(posedge clk) disable iff (rst)
      (wb_ack_o && $past(wb_adr_i) == OFS_CTL) |-> wb_dat_o[B_PIN_CHANGE_SUMMARY_FLAG] == $past(|s.ioc);
   endproperty
   a_sum: assert property (p_sum) else $error("summary flag wrong");
   property p_gate;
      @(posedge clk) disable iff (rst)
      (!s.ctl[B_PERIPH_IRQ_GATE] && s.ctl[5:1] == 5'h0 && s.ioc == 8'h0) |=> !core_req;
   endproperty
   a_gate: assert property (p_gate) else $error("peripheral gate leak");
   property p_stable_sh;
      @(posedge clk) disable iff (rst) restore_go |-> $stable(restore_status);
   endproperty
   a_stable_sh: assert property (p_stable_sh) else $error("shadow moved at return");
   property p_pie_rw;
      @(posedge clk) disable iff (rst)
      (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_PIE)
         |=> s.pie == $past(wb_dat_i[7:0]);
   endproperty
   a_pie_rw: assert property (p_pie_rw) else $error("enable write lost");
   property p_ext;
      @(posedge clk) disable iff (rst) ext_edge |=> s.ctl[B_EXTIF];
   endproperty
   a_ext: assert property (p_ext) else $error("edge flag missing");
   property p_ioc;
      @(posedge clk) disable iff (rst) (|pc_chg) |=> (|s.ioc);
   endproperty
   a_ioc: assert property (p_ioc) else $error("pin change flag missing");
   c_entry: cover property (@(posedge clk) disable iff (rst) vec_go);
   c_ret: cover property (@(posedge clk) disable iff (rst) restore_go);
   c_irq: cover property (@(posedge clk) disable iff (rst) irq);
   c_req: cover property (@(posedge clk) disable iff (rst) core_req);
endmodule

// >>> ics_core_model.sv
// Behavioural model of the processor core that faces the interrupt block.
`timescale 1ns/1ps
module ics_core_model
   import ics_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic allow,
   input wire logic ret_req,
   input wire logic fw_we,
   input wire logic [7:0] fw_w,
   input wire logic vec_go,
   input wire logic [14:0] vec_addr,
   input wire logic push_go,
   input wire logic [14:0] push_pc,
   input wire logic pop_go,
   input wire logic restore_go,
   input wire logic [7:0] restore_w,
   input wire logic [7:0] restore_status,
   input wire logic [4:0] restore_bsr,
   input wire logic [15:0] restore_fsr0,
   input wire logic [15:0] restore_fsr1,
   input wire logic [6:0] restore_pcl,
   output logic core_boundary,
   output logic core_ret,
   output logic [14:0] live_pc,
   output logic [7:0] live_w,
   output logic [7:0] live_status,
   output logic [4:0] live_bsr,
   output logic [15:0] live_fsr0,
   output logic [15:0] live_fsr1,
   output logic [6:0] live_pcl
);
   logic [14:0] stack;
   assign core_boundary = allow;
   assign core_ret = ret_req;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         live_pc <= 15'h0123;
         live_w <= 8'h5a;
         live_status <= 8'hff;
         live_bsr <= 5'h0a;
         live_fsr0 <= 16'h1234;
         live_fsr1 <= 16'h5678;
         live_pcl <= 7'h33;
         stack <= 15'h0000;
      end else begin
         if (push_go) stack <= push_pc;
         if (vec_go) live_pc <= vec_addr;
         // firmware keeps rest
         // The routine disturbs only the shadowed registers, so nothing else needs saving.
         if (fw_we) begin
            live_w <= fw_w;
            live_bsr <= ~live_bsr;
         end
         if (pop_go) live_pc <= stack;
         // Timeout and powerdown bits are not shadowed, so the core keeps its own.
         if (restore_go) begin
            live_w <= restore_w;
            live_status <= (restore_status & 8'he7) | (live_status & 8'h18);
            live_bsr <= restore_bsr;
            live_fsr0 <= restore_fsr0;
            live_fsr1 <= restore_fsr1;
            live_pcl <= restore_pcl;
         end
      end
   end
endmodule

// >>> testbench.sv
// Self-checking bench for the interrupt control and context save block.
`timescale 1ns/1ps
module testbench;
   import ics_pkg::*;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00, pin_change_in = 8'h00, periph_evt = 8'h00, fw_w = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0, wb_dat_o, q;
   logic tick0_ovf = 1'b0, ext_pin = 1'b0, allow = 1'b0, ret_req = 1'b0, fw_we = 1'b0;
   logic wb_ack_o, core_boundary, core_ret, core_req, vec_go, push_go, pop_go, restore_go, irq;
   logic [14:0] live_pc, vec_addr, push_pc;
   logic [7:0] live_w, live_status, restore_w, restore_status;
   logic [4:0] live_bsr, restore_bsr;
   logic [15:0] live_fsr0, live_fsr1, restore_fsr0, restore_fsr1;
   logic [6:0] live_pcl, restore_pcl;
   int n_errors = 0, n_compared = 0, cycles = 0;
   always #50 clk = ~clk;
   ics_irq u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .tick0_ovf(tick0_ovf), .ext_pin(ext_pin), .pin_change_in(pin_change_in),
      .periph_evt(periph_evt), .core_boundary(core_boundary), .core_ret(core_ret),
      .live_pc(live_pc), .live_w(live_w), .live_status(live_status), .live_bsr(live_bsr),
      .live_fsr0(live_fsr0), .live_fsr1(live_fsr1), .live_pcl(live_pcl), .core_req(core_req),
      .vec_go(vec_go), .vec_addr(vec_addr), .push_go(push_go), .push_pc(push_pc),
      .pop_go(pop_go), .restore_go(restore_go), .restore_w(restore_w),
      .restore_status(restore_status), .restore_bsr(restore_bsr), .restore_fsr0(restore_fsr0),
      .restore_fsr1(restore_fsr1), .restore_pcl(restore_pcl), .irq(irq));
   ics_core_model u_core (.clk(clk), .rst(rst), .allow(allow), .ret_req(ret_req),
      .fw_we(fw_we), .fw_w(fw_w), .vec_go(vec_go), .vec_addr(vec_addr), .push_go(push_go),
      .push_pc(push_pc), .pop_go(pop_go), .restore_go(restore_go), .restore_w(restore_w),
      .restore_status(restore_status), .restore_bsr(restore_bsr), .restore_fsr0(restore_fsr0),
      .restore_fsr1(restore_fsr1), .restore_pcl(restore_pcl), .core_boundary(core_boundary),
      .core_ret(core_ret), .live_pc(live_pc), .live_w(live_w), .live_status(live_status),
      .live_bsr(live_bsr), .live_fsr0(live_fsr0), .live_fsr1(live_fsr1), .live_pcl(live_pcl));
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, 4'h3};
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) n_errors++;
      q = wb_dat_o;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic pulse(input int k);
      @(posedge clk);
      tick0_ovf <= (k == 0);
      periph_evt <= (k == 1) ? 8'h40 : 8'h00;
      fw_we <= (k == 2);
      ret_req <= (k == 3);
      @(posedge clk);
      {tick0_ovf, periph_evt, fw_we, ret_req} <= '0;
      repeat (3) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         summarize();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      wb(0, OFS_CTL, 0);
      chk("ctl reset", 32'h0, q);
      wb(0, OFS_PIE, 0);
      chk("pie reset", 32'h0, q);
      wb(1, OFS_PIE, 32'hff);
      wb(0, OFS_PIE, 0);
      chk("pie all", 32'hff, q);
      wb(1, OFS_PIE, 0);
      wb(1, OFS_CTL, 1);
      wb(0, OFS_CTL, 0);
      chk("ctl0 ro", 32'h0, q);
      wb(0, 8'h40, 0);
      chk("unmapped", 32'h0, q);
      $display("test registers done");
      @(posedge clk);
      {ext_pin, pin_change_in} <= {1'b1, 8'h01};
      pulse(0);
      repeat (6) @(posedge clk);
      wb(0, OFS_CTL, 0);
      chk("ctl flags", 32'h07, q);
      chk("no req", 32'h0, core_req);
      wb(1, OFS_CTL, 0);
      wb(0, OFS_CTL, 0);
      chk("summary held", 32'h01, q);
      wb(1, OFS_IOC, 0);
      wb(0, OFS_CTL, 0);
      chk("summary clr", 32'h0, q);
      $display("test flags done");
      wb(1, OFS_EVT_EN, 1);
      wb(1, OFS_CTL, 32'ha0); // flags cleared before enable
      allow <= 1'b1;
      pulse(0);
      for (int i = 0; i < 20 && live_pc !== IRQ_VECTOR; i++) @(posedge clk);
      allow <= 1'b0;
      chk("vector", IRQ_VECTOR, live_pc);
      chk("pushed", 15'h0123, u_core.stack);
      wb(0, OFS_CTL, 0);
      chk("gie off", 32'h24, q);
      wb(0, OFS_SH_W, 0);
      chk("sh w", 32'h5a, q);
      wb(0, OFS_SH_ST, 0);
      chk("sh status", 32'he7, q);
      wb(0, OFS_SH_BSR, 0);
      chk("sh bank", 32'h0a, q);
      wb(0, OFS_SH_FSR0, 0);
      chk("sh ptr", 32'h1234, q);
      wb(0, OFS_SH_FSR1, 0);
      chk("sh ptr1", 32'h5678, q);
      wb(0, OFS_SH_PCL, 0);
      chk("sh page", 32'h33, q);
      chk("irq on", 32'h1, irq);
      wb(1, OFS_EVT_CLR, 1);
      repeat (2) @(posedge clk);
      chk("irq clr", 32'h0, irq);
      wb(1, OFS_SH_W, 32'h3c);
      wb(1, OFS_SH_FSR1, 32'h9abc);
      fw_w <= 8'h99;
      pulse(2);
      wb(1, OFS_CTL, 32'h20);
      pulse(3);
      chk("w restored", 32'h3c, live_w);
      chk("bank restored", 32'h0a, live_bsr);
      chk("ptr1 restored", 32'h9abc, live_fsr1);
      chk("ptr restored", 32'h1234, live_fsr0);
      chk("status restored", 32'hff, live_status);
      chk("page restored", 32'h33, live_pcl);
      chk("popped", 15'h0123, live_pc);
      wb(0, OFS_CTL, 0);
      chk("gie on", 32'ha0, q);
      chk("irq masked", 32'h0, irq);
      wb(0, OFS_EVT_ST, 0);
      chk("events", 32'h2, q);
      $display("test context done");
      wb(1, OFS_PIE, 32'h40);
      pulse(1);
      chk("gated", 32'h0, core_req);
      wb(0, OFS_PIR, 0);
      chk("pflag", 32'h40, q);
      wb(1, OFS_CTL, 32'hc0);
      repeat (2) @(posedge clk);
      chk("req", 32'h1, core_req);
      $display("test gating done");
      summarize();
   end
endmodule
